// file: core/tmc_ctrl.v
`timescale 1ns/1ps
`include "tmc_defines.vh"
// Operation
// - falling edge on external interrupt pin sets sticky flag bit 3
// - timer overflow sets sticky flag bit 0
// - unused flag bits read zero; writes only clear flags, never set
// - flag register reads as flags ANDed with interrupt enables
// - control bit 7 low enables pull-ups on port 6 and two port 7 pins
// - control bit 6 global enable: cleared by disable/entry, set by enable/return
// - control bit 5 selects instruction clock or external timer pin
// - control bit 4 picks rising (0) or falling (1) pin edge
// - control bit 3 gives prescaler to timer (0) or watchdog (1)
// - ratio n divides timer by 2^(n+1), watchdog by 2^n
// - direction bit one means high impedance, zero drives output
// - port 6 wake bits active low per pin
// - option bit 6 sets open drain on two port 7 pins
// - watchdog enable works only while build option is zero
// - option bit 4 falling stops oscillator, rising restarts; wake sets it
// - after restart wait about 18 ms start-up before running
// - option bit 3 enables resistor-option read on two port 7 pins
// - option bit 0 active-low wake enable for two port 7 pins
// - enables bits 3 and 0; interrupt needs individual and global enable
// - prescaler clears on timer write or on watchdog clear/sleep, each only while assigned to that one
// - internal timer counts once per instruction cycle, Fosc/2 or Fosc/4
// - watchdog keeps running in sleep, time-out resets device, 18 ms base
module tmc_ctrl #(
   parameter OST_CYC = `TMC_OST_TIME_MS * (`TMC_CLK_HZ / 1000),
   parameter WDT_CYC = `TMC_WDT_TIME_MS * (`TMC_CLK_HZ / 1000)
) (
   input  wire        CLK_I,
   input  wire        RST_B_I,
   input  wire [7:0]  S_AXI_AWADDR_I,
   input  wire        S_AXI_AWVALID_I,
   output wire        S_AXI_AWREADY_O,
   input  wire [31:0] S_AXI_WDATA_I,
   input  wire [3:0]  S_AXI_WSTRB_I,
   input  wire        S_AXI_WVALID_I,
   output wire        S_AXI_WREADY_O,
   output reg  [1:0]  S_AXI_BRESP_O,
   output reg         S_AXI_BVALID_O,
   input  wire        S_AXI_BREADY_I,
   input  wire [7:0]  S_AXI_ARADDR_I,
   input  wire        S_AXI_ARVALID_I,
   output wire        S_AXI_ARREADY_O,
   output reg  [31:0] S_AXI_RDATA_O,
   output reg  [1:0]  S_AXI_RRESP_O,
   output reg         S_AXI_RVALID_O,
   input  wire        S_AXI_RREADY_I,
   input  wire        BUILD_WDT_OPT_I,
   input  wire        CLK_DIV4_OPT_I,
   input  wire        TIMER_PIN_I,
   input  wire        EXT_INT_N_I,
   input  wire [7:0]  P6_PIN_I,
   input  wire [1:0]  P7_WAKE_PIN_I,
   output wire [7:0]  P5_OE_O,
   output wire [7:0]  P6_OE_O,
   output wire [7:0]  P7_OE_O,
   output wire        PULLUP_EN_O,
   output wire [7:0]  P6_WAKE_EN_O,
   output wire        P7_WAKE_EN_O,
   output wire        OPEN_DRAIN_O,
   output wire        ROPT_READ_O,
   output wire        WDT_ACTIVE_O,
   output reg         WDT_RESET_O,
   output wire        IRQ_REQ_O,
   output wire        OSC_RUN_O,
   output wire        CPU_STALL_O
);
   // ------------------------------------------------------------
   // local constants
   // ------------------------------------------------------------
   localparam [2:0] ST_RUN   = 3'b001;
   localparam [2:0] ST_SLEEP = 3'b010;
   localparam [2:0] ST_START = 3'b100;
   localparam [23:0] OST_LAST = OST_CYC - 1;
   localparam [23:0] WDT_LAST = WDT_CYC - 1;
   localparam [1:0] RESP_OK  = 2'b00;
   localparam [1:0] RESP_DEC = 2'b11;

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   // true when the low k bits of cnt are all ones
   function prescale_hit;
      input [7:0] cnt;
      input [3:0] k;
      reg   [7:0] m;
      begin
         m = ~(8'hFF << k);
         prescale_hit = ((cnt & m) == m);
      end
   endfunction

   function addr_known;
      input [7:0] a;
      begin
         addr_known = (a == `TMC_OFF_TIMER) || (a == `TMC_OFF_CTRL) || (a == `TMC_OFF_P5DIR) ||
                      (a == `TMC_OFF_P6DIR) || (a == `TMC_OFF_P7DIR) || (a == `TMC_OFF_P6WAKE) ||
                      (a == `TMC_OFF_OPTION) || (a == `TMC_OFF_IRQEN) || (a == `TMC_OFF_FLAGS) ||
                      (a == `TMC_OFF_CMD);
      end
   endfunction

   // ------------------------------------------------------------
   // registers and state
   // ------------------------------------------------------------
   reg  [7:0]  timer_count;
   reg  [7:0]  timer_prescale_control;
   reg  [7:0]  port5_direction;
   reg  [7:0]  port6_direction;
   reg  [7:0]  port7_direction;
   reg  [7:0]  port6_wake_control;
   reg  [7:0]  watchdog_sleep_option;
   reg  [7:0]  interrupt_enables;
   reg  [7:0]  interrupt_flags;
   reg  [7:0]  prescaler;
   reg  [23:0] wdt_cnt;
   reg  [23:0] ost_cnt;
   reg  [2:0]  osc_state;
   reg  [1:0]  div_cnt;
   reg         aw_held;
   reg  [7:0]  aw_addr;
   reg         w_held;
   reg  [31:0] w_data;
   reg         w_lane0;
   reg  [10:0] sync1;
   reg  [10:0] sync2;
   reg  [1:0]  pin_last;

   // ------------------------------------------------------------
   // synchronisers
   // ------------------------------------------------------------
   wire        tmr_pin   = sync2[0];
   wire        int_n_pin = sync2[1];
   wire [7:0]  p6_pin    = sync2[9:2];
   wire        p7_low    = (sync2[10] == 1'b0);

   always @(posedge CLK_I) begin
      if (!RST_B_I) begin
         sync1    <= 11'h7FF;
         sync2    <= 11'h7FF;
         pin_last <= 2'h3;
      end else begin
         sync1    <= {&P7_WAKE_PIN_I, P6_PIN_I, EXT_INT_N_I, TIMER_PIN_I};
         sync2    <= sync1;
         pin_last <= {int_n_pin, tmr_pin};
      end
   end

   // ------------------------------------------------------------
   // register bus
   // ------------------------------------------------------------
   assign S_AXI_AWREADY_O = !aw_held && !S_AXI_BVALID_O;
   assign S_AXI_WREADY_O  = !w_held && !S_AXI_BVALID_O;
   assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;

   wire wr_go = aw_held && w_held && !S_AXI_BVALID_O;
   wire wr_ok = wr_go && addr_known(aw_addr) && w_lane0;
   wire [7:0] wd = w_data[7:0];
   wire wr_timer  = wr_ok && (aw_addr == `TMC_OFF_TIMER);
   wire wr_ctrl   = wr_ok && (aw_addr == `TMC_OFF_CTRL);
   wire wr_option = wr_ok && (aw_addr == `TMC_OFF_OPTION);
   wire wr_flags  = wr_ok && (aw_addr == `TMC_OFF_FLAGS);
   wire wr_cmd    = wr_ok && (aw_addr == `TMC_OFF_CMD);
   wire cmd_dis   = wr_cmd && wd[`TMC_CMD_DISABLE];
   wire cmd_ena   = wr_cmd && (wd[`TMC_CMD_ENABLE] || wd[`TMC_CMD_RETURN]);
   wire cmd_entry = wr_cmd && wd[`TMC_CMD_ENTRY];
   wire cmd_wdclr = wr_cmd && (wd[`TMC_CMD_WDTCLR] || wd[`TMC_CMD_SLEEP]);

   always @(posedge CLK_I) begin
      if (!RST_B_I) begin
         aw_held        <= 1'b0;
         aw_addr        <= 8'h00;
         w_held         <= 1'b0;
         w_data         <= 32'h00000000;
         w_lane0        <= 1'b0;
         S_AXI_BVALID_O <= 1'b0;
         S_AXI_BRESP_O  <= RESP_OK;
      end else begin
         if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
            aw_held <= 1'b1;
            aw_addr <= {S_AXI_AWADDR_I[7:2], 2'b00};
         end
         if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
            w_held  <= 1'b1;
            w_data  <= S_AXI_WDATA_I;
            w_lane0 <= S_AXI_WSTRB_I[0];
         end
         if (wr_go) begin
            aw_held        <= 1'b0;
            w_held         <= 1'b0;
            S_AXI_BVALID_O <= 1'b1;
            S_AXI_BRESP_O  <= addr_known(aw_addr) ? RESP_OK : RESP_DEC;
         end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
            S_AXI_BVALID_O <= 1'b0;
         end
      end
   end

   reg [7:0] rd_val;
   wire [7:0] ar_addr = {S_AXI_ARADDR_I[7:2], 2'b00};
   always @* begin
      rd_val = 8'h00;
      case (ar_addr)
         `TMC_OFF_TIMER:  rd_val = timer_count;
         `TMC_OFF_CTRL:   rd_val = timer_prescale_control;
         `TMC_OFF_P5DIR:  rd_val = port5_direction;
         `TMC_OFF_P6DIR:  rd_val = port6_direction;
         `TMC_OFF_P7DIR:  rd_val = port7_direction;
         `TMC_OFF_P6WAKE: rd_val = port6_wake_control;
         `TMC_OFF_OPTION: rd_val = watchdog_sleep_option;
         `TMC_OFF_IRQEN:  rd_val = interrupt_enables;
         `TMC_OFF_FLAGS:  rd_val = interrupt_flags & interrupt_enables;
         default:         rd_val = 8'h00;
      endcase
   end

   always @(posedge CLK_I) begin
      if (!RST_B_I) begin
         S_AXI_RVALID_O <= 1'b0;
         S_AXI_RDATA_O  <= 32'h00000000;
         S_AXI_RRESP_O  <= RESP_OK;
      end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
         S_AXI_RVALID_O <= 1'b1;
         S_AXI_RDATA_O  <= {24'h000000, rd_val};
         S_AXI_RRESP_O  <= addr_known(ar_addr) ? RESP_OK : RESP_DEC;
      end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
         S_AXI_RVALID_O <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // instruction clock divider
   // ------------------------------------------------------------
   wire osc_on = osc_state[0];
   wire instr_en = osc_on && (CLK_DIV4_OPT_I ? (div_cnt == 2'd3) : div_cnt[0]);

   always @(posedge CLK_I) begin
      if (!RST_B_I)
         div_cnt <= 2'd0;
      else if (!osc_on)
         div_cnt <= 2'd0;
      else
         div_cnt <= div_cnt + 2'd1;
   end

   // ------------------------------------------------------------
   // timer, prescaler and watchdog
   // ------------------------------------------------------------
   wire [2:0] ratio  = timer_prescale_control[2:0];
   wire       to_wdt = timer_prescale_control[`TMC_CTRL_ASSIGN];
   wire pin_edge = timer_prescale_control[`TMC_CTRL_EDGE] ? (pin_last[0] && !tmr_pin) : (!pin_last[0] && tmr_pin);
   wire tmr_tick = timer_prescale_control[`TMC_CTRL_SRC] ? pin_edge : instr_en;
   wire tmr_step = tmr_tick && (to_wdt || prescale_hit(prescaler, {1'b0, ratio} + 4'd1));
   wire wdt_step = !to_wdt || prescale_hit(prescaler, {1'b0, ratio});
   wire pre_tick = to_wdt ? 1'b1 : tmr_tick;
   wire wdt_on   = !BUILD_WDT_OPT_I && watchdog_sleep_option[`TMC_OPT_WATCHDOG_ENABLE];
   wire wdt_clr  = cmd_wdclr;
   wire tmr_wrap = tmr_step && !wr_timer && (timer_count == 8'hFF);

   always @(posedge CLK_I) begin
      if (!RST_B_I) begin
         timer_count <= `TMC_RST_ZERO;
         prescaler   <= 8'h00;
      end else begin
         if (wr_timer)
            timer_count <= wd;
         else if (tmr_step)
            timer_count <= timer_count + 8'd1;
         if ((wr_timer && !to_wdt) || (wdt_clr && to_wdt))
            prescaler <= 8'h00;
         else if (pre_tick)
            prescaler <= prescaler + 8'd1;
      end
   end

   // free running, also in sleep, reset pulse on time-out
   always @(posedge CLK_I) begin
      if (!RST_B_I) begin
         wdt_cnt     <= 24'd0;
         WDT_RESET_O <= 1'b0;
      end else begin
         WDT_RESET_O <= 1'b0;
         if (wdt_clr || !wdt_on) begin
            wdt_cnt <= 24'd0;
         end else if (wdt_step) begin
            if (wdt_cnt == WDT_LAST) begin
               wdt_cnt     <= 24'd0;
               WDT_RESET_O <= 1'b1;
            end else begin
               wdt_cnt <= wdt_cnt + 24'd1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // interrupt flags and global enable
   // ------------------------------------------------------------
   // falling edge of interrupt pin
   wire ext_fall = pin_last[1] && !int_n_pin;
   reg  [7:0] next_flags;
   always @* begin
      next_flags = interrupt_flags;
      if (wr_flags)
         next_flags = interrupt_flags & wd;
      if (ext_fall)
         next_flags[`TMC_FLAG_EXT] = 1'b1;
      if (tmr_wrap)
         next_flags[`TMC_FLAG_TMR] = 1'b1;
      next_flags = next_flags & `TMC_MASK_FLAGS;
   end

   always @(posedge CLK_I) begin
      if (!RST_B_I) begin
         interrupt_flags        <= `TMC_RST_ZERO;
         interrupt_enables      <= `TMC_RST_ZERO;
         timer_prescale_control <= `TMC_RST_CTRL;
      end else begin
         interrupt_flags <= next_flags;
         if (wr_ok && (aw_addr == `TMC_OFF_IRQEN))
            interrupt_enables <= wd & `TMC_MASK_FLAGS;
         if (wr_ctrl)
            timer_prescale_control <= {wd[7], timer_prescale_control[`TMC_CTRL_GIE], wd[5:0]};
         if (cmd_dis || cmd_entry)
            timer_prescale_control[`TMC_CTRL_GIE] <= 1'b0;
         else if (cmd_ena)
            timer_prescale_control[`TMC_CTRL_GIE] <= 1'b1;
      end
   end

   assign IRQ_REQ_O = timer_prescale_control[`TMC_CTRL_GIE] && |(interrupt_flags & interrupt_enables);

   // ------------------------------------------------------------
   // port control registers
   // ------------------------------------------------------------
   always @(posedge CLK_I) begin
      if (!RST_B_I) begin
         port5_direction    <= `TMC_RST_DIR;
         port6_direction    <= `TMC_RST_DIR;
         port7_direction    <= `TMC_RST_DIR;
         port6_wake_control <= `TMC_RST_P6WAKE;
      end else begin
         if (wr_ok && (aw_addr == `TMC_OFF_P5DIR))
            port5_direction <= wd;
         if (wr_ok && (aw_addr == `TMC_OFF_P6DIR))
            port6_direction <= wd;
         if (wr_ok && (aw_addr == `TMC_OFF_P7DIR))
            port7_direction <= wd;
         if (wr_ok && (aw_addr == `TMC_OFF_P6WAKE))
            port6_wake_control <= wd;
      end
   end

   assign P5_OE_O = ~port5_direction;
   assign P6_OE_O = ~port6_direction;
   assign P7_OE_O = ~port7_direction;
   assign PULLUP_EN_O  = !timer_prescale_control[`TMC_CTRL_PULLUP_N];
   assign P6_WAKE_EN_O = ~port6_wake_control;
   assign P7_WAKE_EN_O = !watchdog_sleep_option[`TMC_OPT_WAKE7_N];
   assign OPEN_DRAIN_O = watchdog_sleep_option[`TMC_OPT_ODE];
   assign ROPT_READ_O  = watchdog_sleep_option[`TMC_OPT_ROC];
   assign WDT_ACTIVE_O = wdt_on;

   // ------------------------------------------------------------
   // oscillator control and start-up delay
   // ------------------------------------------------------------
   // wake is a low level, sampled only in the sleep state, so a held pin sets the bit once
   wire wake_lvl = (|(~p6_pin & ~port6_wake_control)) || (p7_low && P7_WAKE_EN_O);
   wire hw_wake  = osc_state[1] && wake_lvl;
   reg  [7:0] next_option;
   always @* begin
      next_option = watchdog_sleep_option;
      if (wr_option)
         next_option = wd & `TMC_MASK_OPTION;
      // hardware wake sets the oscillator and watchdog enable bits, winning over a clear
      if (hw_wake) begin
         next_option[`TMC_OPT_OSC]  = 1'b1;
         next_option[`TMC_OPT_WATCHDOG_ENABLE] = 1'b1;
      end
   end

   wire osc_bit  = watchdog_sleep_option[`TMC_OPT_OSC];
   wire osc_fall = osc_bit && !next_option[`TMC_OPT_OSC];
   wire osc_rise = !osc_bit && next_option[`TMC_OPT_OSC];

   always @(posedge CLK_I) begin
      if (!RST_B_I) begin
         watchdog_sleep_option <= `TMC_RST_OPTION;
         osc_state             <= ST_RUN;
         ost_cnt               <= 24'd0;
      end else begin
         watchdog_sleep_option <= next_option;
         case (osc_state)
            ST_RUN: begin
               if (osc_fall)
                  osc_state <= ST_SLEEP;
            end
            ST_SLEEP: begin
               if (osc_rise) begin
                  osc_state <= ST_START;
                  ost_cnt   <= 24'd0;
               end
            end
            ST_START: begin
               if (ost_cnt == OST_LAST)
                  osc_state <= ST_RUN;
               else
                  ost_cnt <= ost_cnt + 24'd1;
            end
            default: osc_state <= ST_RUN;
         endcase
      end
   end

   // instruction clock is held off during start-up, the bus stays live
   assign OSC_RUN_O   = !osc_state[1];
   assign CPU_STALL_O = !osc_state[0];

endmodule // tmc_ctrl

// file: inc/tmc_defines.vh
`ifndef TMC_DEFINES_VH
`define TMC_DEFINES_VH
// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define TMC_OFF_TIMER      8'h00
`define TMC_OFF_CTRL       8'h04
`define TMC_OFF_P5DIR      8'h08
`define TMC_OFF_P6DIR      8'h0C
`define TMC_OFF_P7DIR      8'h10
`define TMC_OFF_P6WAKE     8'h14
`define TMC_OFF_OPTION     8'h18
`define TMC_OFF_IRQEN      8'h1C
`define TMC_OFF_FLAGS      8'h20
`define TMC_OFF_CMD        8'h24
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define TMC_CTRL_PULLUP_N  7
`define TMC_CTRL_GIE       6
`define TMC_CTRL_SRC       5
`define TMC_CTRL_EDGE      4
`define TMC_CTRL_ASSIGN    3
`define TMC_OPT_ODE        6
`define TMC_OPT_WATCHDOG_ENABLE       5
`define TMC_OPT_OSC        4
`define TMC_OPT_ROC        3
`define TMC_OPT_WAKE7_N    0
`define TMC_FLAG_EXT       3
`define TMC_FLAG_TMR       0
`define TMC_CMD_DISABLE    0
`define TMC_CMD_ENABLE     1
`define TMC_CMD_RETURN     2
`define TMC_CMD_WDTCLR     3
`define TMC_CMD_SLEEP      4
`define TMC_CMD_ENTRY      5
// ------------------------------------------------------------
// reset values and masks
// ------------------------------------------------------------
`define TMC_RST_CTRL       8'hBF
`define TMC_RST_DIR        8'hFF
`define TMC_RST_P6WAKE     8'hFF
`define TMC_RST_OPTION     8'h31
`define TMC_RST_ZERO       8'h00
`define TMC_MASK_OPTION    8'h79
`define TMC_MASK_FLAGS     8'h09
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define TMC_CLK_HZ         10000000
`define TMC_OST_TIME_MS    18
`define TMC_WDT_TIME_MS    18
`endif

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
   reg         clk, rst_b, awv, wv, arv, build, div4, tmr, irq, wake;
   reg  [7:0]  awa, ara, v;
   reg  [31:0] wdat;
   wire        awrdy, wrdy, bvalid, arrdy, rvalid, wdt_act, wdt_rst, irq_req, osc_run, stall, tpin, ipin;
   wire [1:0]  bresp, rresp, p7;
   wire [31:0] rdata;
   wire [7:0]  p6;
   integer     err_total, checks_done, i, n, e;
   integer     cyc = 0;
   reg  [25:0] rows [0:8] = '{{8'h08,8'hA5,8'hA5,2'h0}, {8'h0C,8'h3C,8'h3C,2'h0}, {8'h10,8'h0F,8'h0F,2'h0},
      {8'h14,8'hFE,8'hFE,2'h0}, {8'h18,8'hFF,8'h79,2'h0}, {8'h1C,8'hFF,8'h09,2'h0},
      {8'h04,8'h4F,8'h0F,2'h0}, {8'h24,8'h00,8'h00,2'h0}, {8'h28,8'h55,8'h00,2'h3}};
   reg  [15:0] rst_rows [0:6] = '{16'h04BF, 16'h0CFF, 16'h1831, 16'h14FF, 16'h1C00, 16'h2000, 16'h0000};
   reg  [31:0] cmds = 32'h02200401;

   tmc_ctrl #(.OST_CYC(16), .WDT_CYC(20)) i_tmc_ctrl (.CLK_I(clk), .RST_B_I(rst_b),
      .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awrdy), .S_AXI_WDATA_I(wdat),
      .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy), .S_AXI_BRESP_O(bresp),
      .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(1'h1), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
      .S_AXI_ARREADY_O(arrdy), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
      .S_AXI_RREADY_I(1'h1), .BUILD_WDT_OPT_I(build), .CLK_DIV4_OPT_I(div4), .TIMER_PIN_I(tpin),
      .EXT_INT_N_I(ipin), .P6_PIN_I(p6), .P7_WAKE_PIN_I(p7), .P5_OE_O(), .P6_OE_O(), .P7_OE_O(),
      .PULLUP_EN_O(), .P6_WAKE_EN_O(), .P7_WAKE_EN_O(), .OPEN_DRAIN_O(), .ROPT_READ_O(),
      .WDT_ACTIVE_O(wdt_act), .WDT_RESET_O(wdt_rst), .IRQ_REQ_O(irq_req), .OSC_RUN_O(osc_run),
      .CPU_STALL_O(stall));
   tmc_pins i_tmc_pins (.tmr_lvl_i(tmr), .irq_lvl_i(irq), .wake_lvl_i(wake), .timer_pin_o(tpin),
      .ext_int_n_o(ipin), .p6_pin_o(p6), .p7_wake_pin_o(p7));

   task chk(input [31:0] s, input [31:0] x);
      begin
         checks_done = checks_done + 1;
         if (s !== x) begin
            err_total = err_total + 1;
            $display("BAD %0t seen %h want %h", $time, s, x);
         end
      end
   endtask
   // ------
   // bus cycles: handshakes sampled mid-cycle, released after the edge
   // ------
   task wr(input [7:0] a, input [7:0] d, input [1:0] r = 2'h0);
      reg ha, hw, hb;
      reg [1:0] rs;
      integer k;
      begin
         @(posedge clk);
         awa <= a;
         wdat <= {24'h0, d};
         awv <= 1'h1;
         wv <= 1'h1;
         k = 0;
         hb = 0;
         while (!hb && k < 50) begin
            @(negedge clk);
            ha = awv && awrdy;
            hw = wv && wrdy;
            hb = bvalid;
            rs = bresp;
            @(posedge clk);
            if (ha) awv <= 1'h0;
            if (hw) wv <= 1'h0;
            k = k + 1;
         end
         chk({hb, rs}, {1'h1, r});
      end
   endtask
   task rd(input [7:0] a, output [7:0] d, input [1:0] r);
      reg ha, hr;
      reg [1:0] rs;
      integer k;
      begin
         @(posedge clk);
         ara <= a;
         arv <= 1'h1;
         k = 0;
         hr = 0;
         while (!hr && k < 50) begin
            @(negedge clk);
            ha = arv && arrdy;
            hr = rvalid;
            d = rdata[7:0];
            rs = rresp;
            @(posedge clk);
            if (ha) arv <= 1'h0;
            k = k + 1;
         end
         chk({hr, rs}, {1'h1, r});
      end
   endtask
   task rc(input [7:0] a, input [7:0] x);
      begin
         rd(a, v, 2'h0);
         chk(v, x);
      end
   endtask
   task tk(input integer c);
      repeat (c) @(posedge clk);
   endtask
   task print_verdict;
      begin
         $display("checks %0d errors %0d", checks_done, err_total);
         if (err_total == 0 && checks_done > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask

   initial begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   // the whole run needs well under 12000 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total = err_total + 1;
         print_verdict;
      end
   end

   initial begin
      {rst_b, awv, wv, arv, build, div4, awa, ara, wdat} = 0;
      {tmr, irq, wake} = 3'h7;
      err_total = 0;
      checks_done = 0;
      tk(10);
      rst_b <= 1'h1;
      for (i = 0; i < 7; i = i + 1)
         rc(rst_rows[i][15:8], rst_rows[i][7:0]);
      for (i = 0; i < 9; i = i + 1) begin
         wr(rows[i][25:18], rows[i][17:10], rows[i][1:0]);
         rd(rows[i][25:18], v, rows[i][1:0]);
         chk(v, rows[i][9:2]);
      end
      for (i = 0; i < 5; i = i + 1) begin
         div4 <= (i == 4);
         wr(8'h04, i == 4 ? 8'h00 : i[7:0]);
         wr(8'h00, 8'h00);
         tk(400);
         e = 400 >> (i == 4 ? 3 : i + 2);
         rd(8'h00, v, 2'h0);
         chk(v >= e - 1 && v <= e + 2, 1);
      end
      div4 <= 1'h0;
      wr(8'h1C, 8'h00);
      wr(8'h00, 8'hFF);
      tk(20);
      rc(8'h20, 8'h00);
      wr(8'h1C, 8'h01);
      rc(8'h20, 8'h01);
      wr(8'h20, 8'h00);
      rc(8'h20, 8'h00);
      wr(8'h20, 8'hFF);
      rc(8'h20, 8'h00);
      wr(8'h1C, 8'h08);
      irq <= 1'h0;
      tk(6);
      irq <= 1'h1;
      rc(8'h20, 8'h08);
      @(negedge clk);
      chk(irq_req, 0);
      for (i = 0; i < 4; i = i + 1) begin
         wr(8'h24, cmds[31 - 8 * i -: 8]);
         @(negedge clk);
         chk(irq_req, i % 2 == 0);
      end
      for (e = 0; e < 2; e = e + 1) begin
         wr(8'h04, e ? 8'h38 : 8'h28);
         wr(8'h00, 8'h00);
         tmr <= 1'h0;
         tk(8);
         rc(8'h00, e);
         tmr <= 1'h1;
         tk(8);
         rc(8'h00, 8'h01);
      end
      build <= 1'h1;
      wr(8'h18, 8'h29);
      @(negedge clk);
      chk(wdt_act, 0);
      tk(3);
      wake <= 1'h0;
      @(negedge clk);
      chk({osc_run, stall}, 2'h1);
      n = 0;
      while (!osc_run && n < 100) begin
         @(negedge clk);
         n = n + 1;
      end
      n = 0;
      while (stall && n < 100) begin
         @(negedge clk);
         n = n + 1;
      end
      chk(n >= 12 && n <= 20, 1);
      tk(1);
      wake <= 1'h1;
      rc(8'h18, 8'h39);
      build <= 1'h0;
      wr(8'h18, 8'h31);
      for (e = 0; e < 2; e = e + 1) begin
         wr(8'h04, 8'h08 | e[7:0]);
         n = 0;
         while (!wdt_rst && n < 300) begin
            @(negedge clk);
            n = n + 1;
         end
         n = 0;
         do begin
            @(negedge clk);
            n = n + 1;
         end while (!wdt_rst && n < 300);
         chk(n >= (20 << e) - 1 && n <= (20 << e) + 1, 1);
      end
      print_verdict;
   end
endmodule // tb

// file: tb/tmc_checker.sv
`timescale 1ns/1ps
// ------
// port checks
// ------
module tmc_checker #(
   parameter OST_CYC = 16,
   parameter WDT_CYC = 20
) (
   input wire        CLK_I,
   input wire        RST_B_I,
   input wire [7:0]  S_AXI_AWADDR_I,
   input wire        S_AXI_AWVALID_I,
   input wire        S_AXI_AWREADY_O,
   input wire [31:0] S_AXI_WDATA_I,
   input wire        S_AXI_WVALID_I,
   input wire        S_AXI_WREADY_O,
   input wire [1:0]  S_AXI_BRESP_O,
   input wire        S_AXI_BVALID_O,
   input wire [7:0]  S_AXI_ARADDR_I,
   input wire        S_AXI_ARVALID_I,
   input wire        S_AXI_ARREADY_O,
   input wire [31:0] S_AXI_RDATA_O,
   input wire        S_AXI_RVALID_O,
   input wire        BUILD_WDT_OPT_I,
   input wire [7:0]  P5_OE_O,
   input wire        PULLUP_EN_O,
   input wire [7:0]  P6_WAKE_EN_O,
   input wire        P7_WAKE_EN_O,
   input wire        OPEN_DRAIN_O,
   input wire        ROPT_READ_O,
   input wire        WDT_ACTIVE_O,
   input wire        WDT_RESET_O,
   input wire        OSC_RUN_O,
   input wire        CPU_STALL_O
);
   reg [7:0] wa;
   reg [7:0] wd;
   reg [7:0] ra;
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RST_B_I);
   // register fields land on the edge that raises the write response
   always @(posedge CLK_I) begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) wa <= S_AXI_AWADDR_I;
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) wd <= S_AXI_WDATA_I[7:0];
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) ra <= S_AXI_ARADDR_I;
   end
   sequence s_wr(logic [7:0] a, logic c);
      $rose(S_AXI_BVALID_O) && wa == a && S_AXI_BRESP_O == 2'h0 && c;
   endsequence
   sequence s_wake;
      $rose(OSC_RUN_O);
   endsequence
   sequence s_start;
      CPU_STALL_O [*8] ##[1:40] !CPU_STALL_O;
   endsequence
   a_dir_drive: assert property (s_wr(8'h08, 1'h1) |-> P5_OE_O == ~wd)
      else $error("drive enables differ from direction");
   a_pullup_ctl: assert property (s_wr(8'h04, 1'h1) |-> PULLUP_EN_O == !wd[7])
      else $error("pull-up enable wrong");
   a_wake_p6: assert property (s_wr(8'h14, 1'h1) |-> P6_WAKE_EN_O == ~wd)
      else $error("port 6 wake enables wrong");
   a_opt_fields: assert property (s_wr(8'h18, 1'h1) |-> {OPEN_DRAIN_O, ROPT_READ_O, P7_WAKE_EN_O} == {wd[6], wd[3], !wd[0]})
      else $error("option outputs wrong");
   a_sleep_enter: assert property (s_wr(8'h18, !wd[4]) |-> ##[0:2] !OSC_RUN_O)
      else $error("oscillator kept running");
   a_flag_unused: assert property (S_AXI_RVALID_O && ra == 8'h20 |-> S_AXI_RDATA_O[7:4] == 4'h0 && S_AXI_RDATA_O[2:1] == 2'h0)
      else $error("unused flag bits set");
   a_wdt_gate: assert property (BUILD_WDT_OPT_I |-> !WDT_ACTIVE_O)
      else $error("watchdog active despite build option");
   a_wdt_pulse: assert property (WDT_RESET_O |-> $past(WDT_ACTIVE_O) ##1 !WDT_RESET_O)
      else $error("watchdog reset bad");
   a_sleep_stall: assert property (!OSC_RUN_O |-> CPU_STALL_O)
      else $error("running while oscillator off");
   a_start_delay: assert property (s_wake |-> s_start)
      else $error("start-up delay wrong");
endmodule // tmc_checker

bind tmc_ctrl tmc_checker #(.OST_CYC(OST_CYC), .WDT_CYC(WDT_CYC)) i_tmc_checker (.CLK_I, .RST_B_I, .S_AXI_AWADDR_I,
   .S_AXI_AWVALID_I, .S_AXI_AWREADY_O, .S_AXI_WDATA_I, .S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BRESP_O,
   .S_AXI_BVALID_O, .S_AXI_ARADDR_I, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RDATA_O, .S_AXI_RVALID_O,
   .BUILD_WDT_OPT_I, .P5_OE_O, .PULLUP_EN_O, .P6_WAKE_EN_O, .P7_WAKE_EN_O, .OPEN_DRAIN_O, .ROPT_READ_O,
   .WDT_ACTIVE_O, .WDT_RESET_O, .OSC_RUN_O, .CPU_STALL_O);

// file: tb/tmc_pins.sv
`timescale 1ns/1ps
// ------
// external pins, driven from the test levels, port 7 tied high
// ------
module tmc_pins (
   input  wire       tmr_lvl_i,
   input  wire       irq_lvl_i,
   input  wire       wake_lvl_i,
   output wire       timer_pin_o,
   output wire       ext_int_n_o,
   output wire [7:0] p6_pin_o,
   output wire [1:0] p7_wake_pin_o
);
   assign timer_pin_o = tmr_lvl_i;
   assign ext_int_n_o = irq_lvl_i;
   // only pin 0 follows the wake level, the rest are held high
   assign p6_pin_o = {7'h7F, wake_lvl_i};
   assign p7_wake_pin_o = 2'h3;
endmodule // tmc_pins
